//--- inc/synth_loader_defines.svh
// Constants for the serial divider loader: register offsets, field positions, resets.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef SYNTH_LOADER_DEFINES_SVH
`define SYNTH_LOADER_DEFINES_SVH

`define SHIFT_LEN 18
`define BIT_CNT_W 5

`define M_MSB 9
`define M_LSB 0
`define N_MSB 12
`define N_LSB 10
`define P_MSB 17
`define P_LSB 13

`define OFF_ACTIVE 8'h00
`define OFF_SHIFT 8'h04
`define OFF_CTRL 8'h08
`define OFF_STATUS 8'h0C

`define CTRL_ALLOW_BIT 0
`define CTRL_DIV_LSB 8
`define CTRL_DIV_MSB 15
`define CTRL_RESET 32'h0000_0101

`define ACTIVE_RESET 18'h00000
`define DIV_RESET 8'h01

`endif

//--- inc/synth_loader_pkg.sv
// Types shared by the serial divider loader modules.
// Assumes synth_loader_defines.svh on the include path.
`include "synth_loader_defines.svh"

package synth_loader_pkg;
   typedef logic [`SHIFT_LEN-1:0] cfg_word_t;
   typedef logic [`BIT_CNT_W-1:0] bit_cnt_t;
   typedef logic [7:0] div_t;
   typedef logic [8:0] half_cnt_t;
endpackage

//--- inc/pin_event_if.sv
// Carrier for one sampled pin: synchronised level and its one-cycle edge pulses.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps

interface pin_event_if;
   logic level;
   logic rise;
   logic fall;
   modport src (output level, output rise, output fall);
   modport dst (input level, input rise, input fall);
endinterface

//--- verilog/pin_sampler.sv
// Two-flop synchroniser for an asynchronous pin, with rise and fall detection.
// Assumes i_pin comes from outside the i_clk domain.
`timescale 1ns/1ps

module pin_sampler
   import synth_loader_pkg::*;
#(
   parameter logic RESET_LEVEL = 1'b0
)
(
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_pin,
   pin_event_if.src ev
);
   logic meta_ff;
   logic sync_ff;
   logic prev_ff;

   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         meta_ff <= RESET_LEVEL;
         sync_ff <= RESET_LEVEL;
         prev_ff <= RESET_LEVEL;
      end
      else
      begin
         meta_ff <= i_pin;
         sync_ff <= meta_ff;
         prev_ff <= sync_ff;
      end
   end

   assign ev.level = sync_ff;
   assign ev.rise = sync_ff & ~prev_ff;
   assign ev.fall = ~sync_ff & prev_ff;
endmodule

//--- verilog/synth_serial_config_loader.sv
// Serial loader for the pre-scale, feedback and output divider settings, with a
// gated synthesised clock and an AHB-Lite register slave.
// Assumes one AHB-Lite master on i_clk; serial pins and the gate pin are asynchronous.
//
// Design decisions made here: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "synth_loader_defines.svh"

// What this block does
// - Holds pre-scale, feedback and output divider values, loaded over the serial port.
// - Each rising shift strobe samples the data pin and shifts exactly once.
// - Serial bits collect in an eighteen-bit shift register before transfer.
// - Rising transfer strobe copies the shift register into the divider latch.
// - Falling transfer strobe locks the transferred values as the active setting.
// - Output gate low disables the synthesised clock output.
// - Output gate high enables the synthesised clock output while the control register allow bit is set.
// - Gate changes take effect only at output clock boundaries, never producing runts.
module synth_serial_config_loader
   import synth_loader_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_serial_in_bit,
   input wire logic i_shift_strobe,
   input wire logic i_transfer_pulse,
   input wire logic i_output_gate,
   output logic o_synth_output,
   output logic [4:0] o_prescale,
   output logic [9:0] o_feedback_div,
   output logic [2:0] o_output_div,
   input wire logic i_hsel,
   input wire logic [31:0] i_haddr,
   input wire logic [1:0] i_htrans,
   input wire logic i_hwrite,
   input wire logic [2:0] i_hsize,
   input wire logic [31:0] i_hwdata,
   input wire logic i_hready,
   output logic [31:0] o_hrdata,
   output logic o_hreadyout,
   output logic o_hresp
);
   pin_event_if data_ev ();
   pin_event_if shift_ev ();
   pin_event_if xfer_ev ();
   pin_event_if gate_ev ();

   pin_sampler #(.RESET_LEVEL(1'b0)) u_data (.i_clk(i_clk), .i_rst(i_rst), .i_pin(i_serial_in_bit), .ev(data_ev));
   pin_sampler #(.RESET_LEVEL(1'b0)) u_shift (.i_clk(i_clk), .i_rst(i_rst), .i_pin(i_shift_strobe), .ev(shift_ev));
   pin_sampler #(.RESET_LEVEL(1'b0)) u_xfer (.i_clk(i_clk), .i_rst(i_rst), .i_pin(i_transfer_pulse), .ev(xfer_ev));
   pin_sampler #(.RESET_LEVEL(1'b0)) u_gate (.i_clk(i_clk), .i_rst(i_rst), .i_pin(i_output_gate), .ev(gate_ev));

   cfg_word_t shift_ff;
   cfg_word_t active_ff;
   bit_cnt_t bit_cnt_ff;
   logic locked_ff;
   logic ctrl_allow_ff;
   div_t ctrl_div_ff;
   half_cnt_t half_cnt_ff;
   half_cnt_t half_limit;
   logic phase_ff;
   logic gate_on_ff;
   logic out_ff;
   logic gate_req;
   logic nxt_phase;
   logic nxt_gate_on;
   logic wrap;

   // Serial shift path; the data pin is sampled as the strobe's rise is seen
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
         shift_ff <= `ACTIVE_RESET;
      else if (shift_ev.rise)
         shift_ff <= {shift_ff[`SHIFT_LEN-2:0], data_ev.level};
   end

   // Count of strobes since the last transfer, saturating at full length
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
         bit_cnt_ff <= '0;
      else if (xfer_ev.rise)
         bit_cnt_ff <= '0;
      else if (shift_ev.rise && bit_cnt_ff != bit_cnt_t'(`SHIFT_LEN))
         bit_cnt_ff <= bit_cnt_ff + bit_cnt_t'(1);
   end

   // Divider latch: written only on the transfer strobe's rise
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
         active_ff <= `ACTIVE_RESET;
      else if (xfer_ev.rise)
         active_ff <= shift_ff;
   end

   // Locked once the strobe falls; reopened by the next rise
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
         locked_ff <= 1'b0;
      else if (xfer_ev.fall)
         locked_ff <= 1'b1;
      else if (xfer_ev.rise)
         locked_ff <= 1'b0;
   end

   // Pre-scale takes the first five bits shifted in, so the port is filled without padding
   assign o_prescale = active_ff[`P_MSB:`P_LSB];
   assign o_feedback_div = active_ff[`M_MSB:`M_LSB];
   assign o_output_div = active_ff[`N_MSB:`N_LSB];

   // Synthesised clock: half period = control divide + output divide field + 1 cycles
   assign half_limit = half_cnt_t'(ctrl_div_ff) + half_cnt_t'(active_ff[`N_MSB:`N_LSB]);
   assign wrap = (half_cnt_ff == half_limit);
   assign nxt_phase = wrap ? ~phase_ff : phase_ff;
   assign gate_req = gate_ev.level & ctrl_allow_ff;

   // Gate is resampled only as the free clock is about to rise, so highs are never cut
   always_comb
   begin
      nxt_gate_on = gate_on_ff;
      if (wrap && !phase_ff)
         nxt_gate_on = gate_req;
   end

   always_ff @(posedge i_clk)
   begin
      if (i_rst)
         half_cnt_ff <= '0;
      else if (wrap)
         half_cnt_ff <= '0;
      else
         half_cnt_ff <= half_cnt_ff + half_cnt_t'(1);
   end

   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         phase_ff <= 1'b0;
         gate_on_ff <= 1'b0;
         out_ff <= 1'b0;
      end
      else
      begin
         phase_ff <= nxt_phase;
         gate_on_ff <= nxt_gate_on;
         out_ff <= nxt_phase & nxt_gate_on;
      end
   end

   assign o_synth_output = out_ff;

   // AHB-Lite slave: zero wait states, always OKAY
   logic dphase_wr_ff;
   logic [7:0] dphase_addr_ff;
   logic [7:0] aaddr;
   logic take;
   logic [31:0] rd_mux;

   assign aaddr = i_haddr[7:0];
   assign take = i_hsel & i_htrans[1] & i_hready;
   assign o_hreadyout = 1'b1;
   assign o_hresp = 1'b0;

   always_comb
   begin
      rd_mux = 32'h0000_0000;
      case (aaddr)
         `OFF_ACTIVE: rd_mux = {14'h0000, active_ff};
         `OFF_SHIFT: rd_mux = {14'h0000, shift_ff};
         `OFF_CTRL: rd_mux = {16'h0000, ctrl_div_ff, 7'h00, ctrl_allow_ff};
         `OFF_STATUS: rd_mux = {24'h00_0000, gate_on_ff, locked_ff, 1'b0, bit_cnt_ff};
         default: rd_mux = 32'h0000_0000;
      endcase
      // A read right behind a control write sees the word being written, not the stale one
      if (dphase_wr_ff && dphase_addr_ff == `OFF_CTRL && aaddr == `OFF_CTRL)
      begin
         rd_mux = {16'h0000, i_hwdata[`CTRL_DIV_MSB:`CTRL_DIV_LSB], 7'h00, i_hwdata[`CTRL_ALLOW_BIT]};
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (i_rst)
         o_hrdata <= 32'h0000_0000;
      else if (take && !i_hwrite)
         o_hrdata <= rd_mux;
   end

   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         dphase_wr_ff <= 1'b0;
         dphase_addr_ff <= 8'h00;
      end
      else if (i_hready)
      begin
         dphase_wr_ff <= take & i_hwrite;
         dphase_addr_ff <= aaddr;
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         ctrl_allow_ff <= 1'b1;
         ctrl_div_ff <= `DIV_RESET;
      end
      else if (dphase_wr_ff && dphase_addr_ff == `OFF_CTRL)
      begin
         ctrl_allow_ff <= i_hwdata[`CTRL_ALLOW_BIT];
         ctrl_div_ff <= i_hwdata[`CTRL_DIV_MSB:`CTRL_DIV_LSB];
      end
   end
endmodule

//--- test/synth_loader_assertions.sv
// Checker: latch, gate and bus answers.
// Assumes a bind to the loader top.
`timescale 1ns/1ps
module synth_loader_assertions
(
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_transfer_pulse,
   input wire logic i_output_gate,
   input wire logic o_synth_output,
   input wire logic [4:0] o_prescale,
   input wire logic [9:0] o_feedback_div,
   input wire logic [2:0] o_output_div,
   input wire logic o_hreadyout,
   input wire logic o_hresp
);
   logic [3:0] tp_ff;
   logic [9:0] lo_ff;
   logic [9:0] hi_ff;
   wire [17:0] cfg = {o_prescale, o_output_div, o_feedback_div};
   always_ff @(posedge i_clk)
      tp_ff <= (i_rst || i_transfer_pulse) ? 4'h0 : tp_ff + 4'(tp_ff != 4'hF);
   always_ff @(posedge i_clk)
      lo_ff <= (i_rst || i_output_gate) ? 10'h0 : lo_ff + 10'(lo_ff != 10'h3FF);
   always_ff @(posedge i_clk)
      hi_ff <= (i_rst || !i_output_gate) ? 10'h0 : hi_ff + 10'(hi_ff != 10'h3FF);
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_rst);
   sequence s_load_end; $fell(i_transfer_pulse) ##6 1; endsequence
   property p_bus; o_hreadyout && !o_hresp; endproperty
   property p_load; $rose(i_transfer_pulse) |-> ##[1:6] $changed(cfg); endproperty
   property p_lock; s_load_end |-> $stable(cfg)[*8]; endproperty
   property p_hold; $changed(cfg) |-> tp_ff < 4'h8; endproperty
   property p_off; lo_ff > 10'h258 |-> !o_synth_output; endproperty
   property p_on; hi_ff > 10'h258 |-> ##[1:600] $changed(o_synth_output); endproperty
   property p_high; $rose(o_synth_output) |-> o_synth_output[*2]; endproperty
   property p_low; $fell(o_synth_output) |-> (!o_synth_output)[*2]; endproperty
   a_bus: assert property (p_bus) else $error("bus answer");
   a_load: assert property (p_load) else $error("no load");
   a_lock: assert property (p_lock) else $error("latch moved");
   a_hold: assert property (p_hold) else $error("stray update");
   a_off: assert property (p_off) else $error("output on");
   a_on: assert property (p_on) else $error("output off");
   a_high: assert property (p_high) else $error("runt high");
   a_low: assert property (p_low) else $error("runt low");
endmodule
bind synth_serial_config_loader synth_loader_assertions chk (.*);

//--- test/serial_host.sv
// Host model driving the serial pins.
// Assumes a 400 ns link clock, still between frames.
`timescale 1ns/1ps
module serial_host
(
   output logic o_sd,
   output logic o_sc,
   output logic o_ld
);
   initial
   begin
      o_sd = 0;
      o_sc = 0;
      o_ld = 0;
   end
   task automatic send(input logic [17:0] v);
      #13;
      for (int i = 17; i >= 0; i--)
      begin
         o_sd = v[i];
         #200 o_sc = 1;
         #200 o_sc = 0;
      end
      o_sd = ~o_sd;
   endtask
   task automatic load();
      #200 o_ld = 1;
      #400 o_ld = 0;
      #200;
   endtask
endmodule

//--- test/synth_serial_config_loader_bench.sv
// Bench: serial loads, gate, registers.
// Assumes the host model on the serial pins.
`timescale 1ns/1ps
module synth_serial_config_loader_bench
   import synth_loader_pkg::*;
;
   logic i_clk = 0, i_rst = 1, i_output_gate = 0, i_hsel = 0, i_hwrite = 0, i_hready;
   logic [31:0] i_haddr = 0, i_hwdata = 0, o_hrdata, r, lf = 32'h8AF6;
   logic [1:0] i_htrans = 0;
   logic [2:0] i_hsize = 3'h2, o_output_div;
   logic i_serial_in_bit, i_shift_strobe, i_transfer_pulse, o_synth_output, o_hreadyout, o_hresp;
   logic [4:0] o_prescale;
   logic [9:0] o_feedback_div;
   cfg_word_t act, q[$];
   int fails = 0, compares = 0, cyc = 0, n;
   assign i_hready = o_hreadyout;
   always #25 i_clk = ~i_clk;
   synth_serial_config_loader uut (.*);
   serial_host host (.o_sd(i_serial_in_bit), .o_sc(i_shift_strobe), .o_ld(i_transfer_pulse));
   task automatic chk(input string s, input logic [31:0] e, g);
      compares++;
      if (g !== e)
      begin
         fails++;
         $display("Error %s expected %h seen %h", s, e, g);
      end
   endtask
   function automatic logic [31:0] lfsr(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   task automatic bus(input logic wr, input logic [31:0] a, d);
      i_hsel <= 1;
      i_htrans <= 2'h2;
      i_hwrite <= wr;
      i_haddr <= a;
      do @(posedge i_clk); while (o_hreadyout !== 1);
      i_hsel <= 0;
      i_htrans <= 2'h0;
      i_hwdata <= d;
      do @(posedge i_clk); while (o_hreadyout !== 1);
      r = o_hrdata;
   endtask
   task automatic frame(input cfg_word_t v, input logic ld);
      q.push_back(v);
      host.send(v);
      if (ld)
      begin
         host.load();
         act = q[$];
      end
      @(posedge i_clk);
      chk("pre", act[17:13], o_prescale);
      chk("out", act[12:10], o_output_div);
      chk("fb", act[9:0], o_feedback_div);
      bus(0, 32'h0, 0);
      chk("active", act, r);
      bus(0, 32'h4, 0);
      chk("shift", q[$], r);
      bus(0, 32'hC, 0);
      chk("status", ld ? 32'h40 : 32'h52, r);
   endtask
   task automatic conclude();
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   always @(posedge i_clk)
   begin
      cyc++;
      if (cyc > 8000)
      begin
         fails++;
         conclude();
      end
   end
   initial
   begin
      repeat (4) @(posedge i_clk);
      i_rst <= 0;
      @(posedge i_clk);
      bus(0, 32'h8, 0);
      chk("ctrl", 32'h101, r);
      bus(1, 32'h10, 32'hFFFF_FFFF);
      bus(0, 32'h10, 0);
      chk("unmapped", 0, r);
      bus(1, 32'h8, 32'h201);
      bus(0, 32'h8, 0);
      chk("ctrl2", 32'h201, r);
      $display("t1 end");
      act = 0;
      for (n = 0; n < 4; n++)
      begin
         lf = lfsr(lf);
         frame(n == 0 ? 18'h3FFFF : lf[17:0], 1);
      end
      frame(~act, 0);
      chk("gated", 0, o_synth_output);
      $display("t2 end");
      i_output_gate <= 1;
      n = 0;
      while (o_synth_output !== 1 && n < 900)
      begin
         @(negedge i_clk);
         n++;
      end
      n = 0;
      while (o_synth_output === 1 && n < 900)
      begin
         @(negedge i_clk);
         n++;
      end
      chk("half", 3 + act[12:10], n);
      repeat (700) @(posedge i_clk);
      $display("t3 end");
      conclude();
   end
endmodule
